// *** src/jrts_pkg.sv ***
// Purpose: shared constants and carriers for the jet recipe timing sequencer
// Assumes: 250 MHz system clock
// Notes:   intervals counted in 0.1 ms ticks
package jrts_pkg;
    localparam int          CLK_HZ         = 250_000_000;
    localparam int          TICK_US_X10    = 1;   // tick length in tenths of a millisecond
    localparam int          TICK_CYCLES    = CLK_HZ / 10_000 * TICK_US_X10;
    localparam int          TICKS_PER_SEC  = 10_000;
    localparam int          NUM_RECIPES    = 6;
    localparam int          TIME_W         = 16;
    localparam int          DROP_W         = 16;
    localparam int          SEC_W          = 8;
    // baud, parity and length selection codes
    localparam logic [2:0]  BAUD_115200    = 3'h0;
    localparam logic [2:0]  BAUD_57600     = 3'h1;
    localparam logic [2:0]  BAUD_19200     = 3'h2;
    localparam logic [2:0]  BAUD_9600      = 3'h3;
    localparam logic [2:0]  BAUD_4800      = 3'h4;
    localparam logic [1:0]  PAR_NONE       = 2'h0;
    localparam logic [1:0]  PAR_EVEN       = 2'h1;
    localparam logic [1:0]  PAR_ODD        = 2'h2;
    localparam logic        LEN_8BIT       = 1'b0;
    localparam logic        LEN_7BIT       = 1'b1;

    typedef struct packed {
        logic [TIME_W-1:0] open_ticks;
        logic [TIME_W-1:0] closed_ticks;
        logic [TIME_W-1:0] first_extra;
        logic [TIME_W-1:0] idle_extra;
        logic [SEC_W-1:0]  idle_secs;
        logic [DROP_W-1:0] drop_count;
        logic              bead_mode;    // 1: bead (line), 0: spot (drop)
    } jrts_recipe_t;

    typedef struct packed {
        logic [2:0] baud_sel;
        logic [1:0] parity_sel;
        logic       len_sel;
    } jrts_ser_cfg_t;

    typedef struct packed {
        logic [15:0] bit_div;
        logic        parity_en;
        logic        parity_odd;
        logic [3:0]  data_bits;
    } jrts_ser_fmt_t;
endpackage

// *** src/jrts_ser_cfg.sv ***
// Purpose: serial host port format selection (baud divisor, parity, length)
// Assumes: selection codes from jrts_pkg, configuration sampled every clock
// Notes:   unknown codes fall back to the reset defaults
`timescale 1ns/10ps
module jrts_ser_cfg (
    input  wire logic                    clk_sys_i,
    input  wire logic                    rst_b_i,
    input  wire jrts_pkg::jrts_ser_cfg_t cfg_i,
    output jrts_pkg::jrts_ser_fmt_t      fmt_o
);
    typedef struct packed {
        jrts_pkg::jrts_ser_fmt_t fmt;
    } jrts_sc_state_t;

    jrts_sc_state_t state_reg;
    jrts_sc_state_t state_next;

    // divisor of the system clock for one bit time
    function automatic logic [15:0] jrts_div(input logic [2:0] sel);
        case (sel)
            jrts_pkg::BAUD_57600: jrts_div = 16'(jrts_pkg::CLK_HZ / 57600);
            jrts_pkg::BAUD_19200: jrts_div = 16'(jrts_pkg::CLK_HZ / 19200);
            jrts_pkg::BAUD_9600:  jrts_div = 16'(jrts_pkg::CLK_HZ / 9600);
            jrts_pkg::BAUD_4800:  jrts_div = 16'(jrts_pkg::CLK_HZ / 4800);
            default:              jrts_div = 16'(jrts_pkg::CLK_HZ / 115200);
        endcase
    endfunction

    // decode selections into the line format
    always_comb begin
        state_next                = state_reg;
        state_next.fmt.bit_div    = jrts_div(cfg_i.baud_sel);
        state_next.fmt.parity_en  = (cfg_i.parity_sel == jrts_pkg::PAR_EVEN) ||
                                    (cfg_i.parity_sel == jrts_pkg::PAR_ODD);
        state_next.fmt.parity_odd = (cfg_i.parity_sel == jrts_pkg::PAR_ODD);
        state_next.fmt.data_bits  = (cfg_i.len_sel == jrts_pkg::LEN_7BIT) ?
                                    4'h7 : 4'h8;
    end

    // reset gives 115200, no parity, 8 bits
    always_ff @(posedge clk_sys_i) begin
        if (!rst_b_i) begin
            state_reg.fmt.bit_div    <= 16'(jrts_pkg::CLK_HZ / 115200);
            state_reg.fmt.parity_en  <= 1'b0;
            state_reg.fmt.parity_odd <= 1'b0;
            state_reg.fmt.data_bits  <= 4'h8;
        end else begin
            state_reg <= state_next;
        end
    end

    assign fmt_o = state_reg.fmt;
endmodule

// *** src/jrts_top.sv ***
// Purpose: runs a dispensing jet from six stored recipes started by triggers
// Assumes: triggers synchronous to clk_sys_i in timing, but still passed through two flops
// Notes:   recipes arrive as ports; a trigger while busy is dropped
`timescale 1ns/10ps
// What this block does
// - Six independent recipes each hold open, closed, extras, count and mode.
// - Each drop holds the jet open for the recipe open interval, 0.1 ms units.
// - After opening, the jet stays closed for the recipe closed interval.
// - A drop cycle is effective open then closed; bursts repeat at that period.
// - First extra goes on every drop in spot mode, first drop only in bead; idle extra replaces it on a first drop after idling.
// - After idling the programmed seconds, idle extra goes on the next first drop.
// - Trigger input n starts recipe n only.
// - Jet idle flag is high when idle, low while the jet is active.
// - One trigger in counted mode gives exactly the programmed drop count.
// - Serial port offers 115200 to 4800 baud, reset default 115200.
// - Serial port offers none, even or odd parity, default none.
// - Serial port offers 8 or 7 bit characters, default 8.
// - Every accepted trigger produces the programmed number of drops.
// - Triggers arriving before the current cycle completes are ignored.
// - Idle time counts from the last dispense end; longer uses idle extra.
module jrts_top #(
    parameter int TICK_CYCLES = jrts_pkg::TICK_CYCLES,
    parameter int TICKS_PER_SEC = jrts_pkg::TICKS_PER_SEC
) (
    input  wire logic                    clk_sys_i,
    input  wire logic                    rst_b_i,
    input  wire logic [5:0]              trig_i,
    input  wire jrts_pkg::jrts_recipe_t  recipe_i [jrts_pkg::NUM_RECIPES],
    input  wire jrts_pkg::jrts_ser_cfg_t ser_cfg_i,
    output jrts_pkg::jrts_ser_fmt_t      ser_fmt_o,
    output logic                         jet_open_o,
    output logic                         jet_idle_flag_o,
    output logic [2:0]                   active_recipe_o,
    output logic                         trig_dropped_o
);
    // phases of a run: waiting, jet open, jet closed
    typedef enum logic [1:0] {
        JRTS_IDLE,
        JRTS_OPEN,
        JRTS_CLOSED
    } jrts_phase_t;

    // every register of the sequencer, kept together as one word
    // sync3 holds the previous sync2 sample so each edge is seen exactly once
    typedef struct packed {
        logic [5:0]                     sync1;
        logic [5:0]                     sync2;
        logic [5:0]                     sync3;
        logic [15:0]                    pre_cnt;
        logic                           tick;
        logic [15:0]                    sec_div;
        logic [jrts_pkg::SEC_W-1:0]     idle_sec;
        jrts_phase_t                    phase;
        jrts_pkg::jrts_recipe_t         rcp;
        logic [jrts_pkg::TIME_W:0]      phase_cnt;
        logic [jrts_pkg::DROP_W-1:0]    drops_left;
        logic                           first_drop;
        logic                           use_idle;
        logic                           jet_open;
        logic                           idle_flag;
        logic [2:0]                     active;
        logic                           dropped;
    } jrts_state_t;

    // present and next state of the whole sequencer
    jrts_state_t state_reg;
    jrts_state_t state_next;

    // lowest set bit index of the trigger edge vector
    function automatic logic [2:0] jrts_pick(input logic [5:0] v);
        jrts_pick = 3'h0;
        for (int i = 5; i >= 0; i--) begin
            if (v[i]) begin
                jrts_pick = 3'(i);
            end
        end
    endfunction

    // open time of a drop including any extras
    function automatic logic [jrts_pkg::TIME_W:0] jrts_open_len(
        input jrts_pkg::jrts_recipe_t r,
        input logic                   first,
        input logic                   idle_long
    );
        logic [jrts_pkg::TIME_W:0] extra;
        extra = '0;
        if (first && idle_long) begin
            extra = {1'b0, r.idle_extra};
        end else if (first || !r.bead_mode) begin
            extra = {1'b0, r.first_extra};
        end
        jrts_open_len = {1'b0, r.open_ticks} + extra;
    endfunction

    // rising edges of the synchronised triggers, one bit per recipe
    logic [5:0] trig_rise;

    // serial host port format, registered in its own module
    jrts_ser_cfg u_ser_cfg (
        .clk_sys_i (clk_sys_i),
        .rst_b_i   (rst_b_i),
        .cfg_i     (ser_cfg_i),
        .fmt_o     (ser_fmt_o)
    );

    // edges seen by the second and third stage only
    assign trig_rise = state_reg.sync2 & ~state_reg.sync3;

    // sequencing of ticks, idle time and drop phases
    always_comb begin
        state_next         = state_reg;
        state_next.sync1   = trig_i;
        state_next.sync2   = state_reg.sync1;
        state_next.sync3   = state_reg.sync2;
        state_next.dropped = 1'b0;
        state_next.tick    = 1'b0;
        // tenth-millisecond time base
        if (state_reg.pre_cnt == 16'(TICK_CYCLES - 1)) begin
            state_next.pre_cnt = '0;
            state_next.tick    = 1'b1;
        end else begin
            state_next.pre_cnt = state_reg.pre_cnt + 16'h0001;
        end
        // idle seconds since the last dispense ended, saturating
        if (state_reg.phase == JRTS_IDLE && state_reg.tick) begin
            if (state_reg.sec_div == 16'(TICKS_PER_SEC - 1)) begin
                state_next.sec_div = '0;
                if (state_reg.idle_sec != '1) begin
                    state_next.idle_sec = state_reg.idle_sec + 1'b1;
                end
            end else begin
                state_next.sec_div = state_reg.sec_div + 16'h0001;
            end
        end
        case (state_reg.phase)
            // idle: an edge on a recipe with drops starts a run
            JRTS_IDLE: begin
                if (trig_rise != 6'h00) begin
                    // trigger n selects recipe n
                    state_next.active     = jrts_pick(trig_rise);
                    state_next.rcp        = recipe_i[jrts_pick(trig_rise)];
                    state_next.use_idle   = state_reg.idle_sec >=
                                            recipe_i[jrts_pick(trig_rise)].idle_secs;
                    state_next.drops_left = recipe_i[jrts_pick(trig_rise)].drop_count;
                    state_next.first_drop = 1'b1;
                    state_next.phase_cnt  = '0;
                    // a recipe with no drops leaves the jet idle
                    if (recipe_i[jrts_pick(trig_rise)].drop_count != '0) begin
                        state_next.phase     = JRTS_OPEN;
                        state_next.jet_open  = 1'b1;
                        state_next.idle_flag = 1'b0;
                    end
                end
            end
            // jet open: count the effective open interval; edges now are refused, not queued
            JRTS_OPEN: begin
                state_next.dropped = trig_rise != 6'h00;
                if (state_reg.tick) begin
                    if (state_reg.phase_cnt + 1'b1 >= jrts_open_len(state_reg.rcp,
                            state_reg.first_drop, state_reg.use_idle)) begin
                        state_next.phase     = JRTS_CLOSED;
                        state_next.jet_open  = 1'b0;
                        state_next.phase_cnt = '0;
                    end else begin
                        state_next.phase_cnt = state_reg.phase_cnt + 1'b1;
                    end
                end
            end
            // jet closed: count the closed interval, then reopen or finish the run
            JRTS_CLOSED: begin
                state_next.dropped = trig_rise != 6'h00;
                if (state_reg.tick) begin
                    // closed interval sets the repeat period in bead mode too
                    if (state_reg.phase_cnt + 1'b1 >=
                            {1'b0, state_reg.rcp.closed_ticks}) begin
                        state_next.phase_cnt  = '0;
                        state_next.first_drop = 1'b0;
                        state_next.drops_left = state_reg.drops_left - 1'b1;
                        if (state_reg.drops_left == 16'h0001) begin
                            state_next.phase     = JRTS_IDLE;
                            state_next.idle_flag = 1'b1;
                            state_next.idle_sec  = '0;
                            state_next.sec_div   = '0;
                        end else begin
                            state_next.phase    = JRTS_OPEN;
                            state_next.jet_open = 1'b1;
                        end
                    end else begin
                        state_next.phase_cnt = state_reg.phase_cnt + 1'b1;
                    end
                end
            end
            // unused encoding: park the jet closed and idle
            default: begin
                state_next.phase     = JRTS_IDLE;
                state_next.jet_open  = 1'b0;
                state_next.idle_flag = 1'b1;
            end
        endcase
    end

    // one register stage for all state; idle counter starts saturated
    always_ff @(posedge clk_sys_i) begin
        if (!rst_b_i) begin
            state_reg           <= '0;
            state_reg.phase     <= JRTS_IDLE;
            state_reg.idle_flag <= 1'b1;
            state_reg.idle_sec  <= '1;
        end else begin
            state_reg <= state_next;
        end
    end

    // every output comes straight from a state flop
    assign jet_open_o      = state_reg.jet_open;
    assign jet_idle_flag_o = state_reg.idle_flag;
    assign active_recipe_o = state_reg.active;
    assign trig_dropped_o  = state_reg.dropped;
endmodule

// *** tb/jrts_robot.sv ***
// Purpose: robot-side trigger source for the jet sequencer
// Assumes: triggers change just after a rising clock edge
// Notes:   a caller may skip the idle wait to provoke a refused trigger
`timescale 1ns/10ps
module jrts_robot (
    input  wire logic       clk_sys_i,
    input  wire logic       jet_idle_flag_i,
    output logic      [5:0] trig_o
);
    // all triggers low from time zero
    initial trig_o = 6'h00;
    // one pulse on trigger k, three clocks wide; single-drop repeats come from here
    task automatic pulse(input int k, input logic wait_idle);
        int w = 0;
        while (wait_idle && jet_idle_flag_i !== 1'b1 && w < 5000) begin
            @(posedge clk_sys_i);
            w++;
        end
        @(posedge clk_sys_i);
        trig_o[k] <= 1'b1;
        repeat (3) @(posedge clk_sys_i);
        trig_o[k] <= 1'b0;
    endtask
endmodule

// *** tb/jrts_top_props.sv ***
// Purpose: port checks for the jet recipe sequencer
// Assumes: one clock, synchronous active-low reset
// Notes:   bound to the top from the bench
`timescale 1ns/10ps
module jrts_top_props #(
    parameter int TICK_CYCLES   = jrts_pkg::TICK_CYCLES,
    parameter int TICKS_PER_SEC = jrts_pkg::TICKS_PER_SEC
) (
    input wire logic                    clk_sys_i,
    input wire logic                    rst_b_i,
    input wire logic [5:0]              trig_i,
    input wire jrts_pkg::jrts_recipe_t  recipe_i [jrts_pkg::NUM_RECIPES],
    input wire jrts_pkg::jrts_ser_cfg_t ser_cfg_i,
    input wire jrts_pkg::jrts_ser_fmt_t ser_fmt_o,
    input wire logic                    jet_open_o,
    input wire logic                    jet_idle_flag_o,
    input wire logic [2:0]              active_recipe_o,
    input wire logic                    trig_dropped_o
);
    default clocking cb @(posedge clk_sys_i); endclocking
    default disable iff (!rst_b_i);
    // run shape: opens first, closes last, flag low while open
    open_not_idle_a: assert property (jet_open_o |-> !jet_idle_flag_o)
        else $error("jet open while idle flag high");
    run_opens_a: assert property ($fell(jet_idle_flag_o) |-> $rose(jet_open_o))
        else $error("run did not begin with the jet opening");
    idle_after_close_a: assert property ($rose(jet_idle_flag_o) |->
        !jet_open_o && $past(jet_open_o) == 1'b0) else $error("run ended without closed time");
    reset_quiet_a: assert property ($rose(rst_b_i) |-> jet_idle_flag_o && !jet_open_o
        && active_recipe_o == 3'h0 && !trig_dropped_o) else $error("bad state after reset");
    drop_pulse_a: assert property (trig_dropped_o |=> !trig_dropped_o)
        else $error("dropped trigger flag longer than one cycle");
    recipe_stable_a: assert property (!jet_idle_flag_o && $past(jet_idle_flag_o) == 1'b0
        |-> $stable(active_recipe_o)) else $error("recipe index moved during a run");
    recipe_range_a: assert property (active_recipe_o < 3'h6)
        else $error("recipe index out of range");
    start_delay_a: assert property ($rose(trig_i[0]) && jet_idle_flag_o
        && recipe_i[0].drop_count != 16'h0000 |-> ##2 jet_idle_flag_o ##1
        (jet_open_o && active_recipe_o == 3'h0)) else $error("trigger start latency wrong");
    baud_map_a: assert property (ser_cfg_i.baud_sel == 3'h0 |=> ser_fmt_o.bit_div == 16'h087a)
        else $error("default baud divisor wrong");
    parity_odd_a: assert property (ser_cfg_i.parity_sel == 2'h2 |=>
        ser_fmt_o.parity_en && ser_fmt_o.parity_odd) else $error("odd parity not selected");
    len_seven_a: assert property (ser_cfg_i.len_sel |=> ser_fmt_o.data_bits == 4'h7)
        else $error("seven bit length not selected");
endmodule

// *** tb/jrts_top_tb.sv ***
// Purpose: self-checking bench for the jet recipe sequencer
// Assumes: short tick and second parameters to keep the run brief
// Notes:   phase lengths are read in ticks, first tick may be partial
`timescale 1ns/10ps
module jrts_top_tb;
    localparam int           TC = 4;
    logic                    clk_sys_i;
    logic                    rst_b_i;
    logic [5:0]              trig;
    jrts_pkg::jrts_recipe_t  rcp [jrts_pkg::NUM_RECIPES];
    jrts_pkg::jrts_ser_cfg_t cfg;
    jrts_pkg::jrts_ser_fmt_t fmt;
    logic                    jet_open;
    logic                    idle;
    logic                    dropped;
    logic                    saw_drop = 1'b0;
    logic [2:0]              act;
    logic [31:0]             opens [$];
    logic [31:0]             busy_t;
    logic [15:0]             divs [6] = '{16'h087a, 16'h10f4, 16'h32dc, 16'h65b9, 16'hcb73, 16'h087a};
    logic [1:0]              par [4] = '{2'h0, 2'h2, 2'h3, 2'h0};
    int                      miscompares = 0;
    int                      num_checks = 0;
    int                      olen = 0;
    int                      blen = 0;

    jrts_top #(.TICK_CYCLES(TC), .TICKS_PER_SEC(10)) i_jrts_top (.clk_sys_i(clk_sys_i),
        .rst_b_i(rst_b_i), .trig_i(trig), .recipe_i(rcp), .ser_cfg_i(cfg), .ser_fmt_o(fmt),
        .jet_open_o(jet_open), .jet_idle_flag_o(idle), .active_recipe_o(act),
        .trig_dropped_o(dropped));
    jrts_robot i_jrts_robot (.clk_sys_i(clk_sys_i), .jet_idle_flag_i(idle), .trig_o(trig));

    // system clock
    initial begin
        clk_sys_i = 1'b0;
        forever #2 clk_sys_i = ~clk_sys_i;
    end

    // length of each open phase and of each busy span, in cycles
    always @(posedge clk_sys_i) begin
        if (dropped === 1'b1) saw_drop <= 1'b1;
        if (jet_open === 1'b1) olen <= olen + 1;
        else if (olen != 0) begin
            opens.push_back(olen);
            olen <= 0;
        end
        if (idle === 1'b0) blen <= blen + 1;
        else if (blen != 0) begin
            busy_t <= blen;
            blen <= 0;
        end
    end

    task automatic check(input logic [31:0] seen, input logic [31:0] exp);
        num_checks++;
        if (seen !== exp) begin
            miscompares++;
            $display("BAD t=%0t seen %0h expected %0h", $time, seen, exp);
        end
    endtask

    function automatic logic [31:0] tk(input logic [31:0] c);
        return (c + TC - 1) / TC;
    endfunction

    // trigger recipe k, wait for the run to end, compare drops and times
    task automatic run(input int k, input int n, input int o1, input int o2, input int bt);
        int w = 0;
        opens.delete();
        i_jrts_robot.pulse(k, 1'b1);
        repeat (3) @(posedge clk_sys_i);
        while (idle !== 1'b1 && w < 5000) begin
            @(posedge clk_sys_i);
            w++;
        end
        @(posedge clk_sys_i);
        #1;
        check(opens.size(), n);
        check(idle, 1'b1);
        if (n > 0) begin
            check(tk(opens[0]), o1);
            check(act, k);
            check(tk(busy_t), bt);
        end
        if (n > 1) check(tk(opens[1]), o2);
        $display("run of recipe %0d finished", k);
    endtask

    task automatic give_verdict();
        $display("checks %0d mismatches %0d", num_checks, miscompares);
        if (miscompares == 0 && num_checks > 0) $display("Result: passed");
        else $display("Result: failed");
        $finish;
    endtask

    // hang guard, far beyond the expected run length
    initial begin
        #40000;
        miscompares++;
        $display("BAD t=%0t watchdog expired", $time);
        give_verdict();
    end

    // main sequence
    initial begin
        rcp[0] = '{16'h0002, 16'h0001, 16'h0001, 16'h0003, 8'h01, 16'h0001, 1'b0};
        rcp[1] = '{16'h0001, 16'h0002, 16'h0002, 16'h0004, 8'hc8, 16'h0003, 1'b1};
        rcp[2] = '{16'h0002, 16'h0001, 16'h0001, 16'h0004, 8'hc8, 16'h0002, 1'b0};
        rcp[3] = '{16'h0002, 16'h0001, 16'h0001, 16'h0004, 8'hc8, 16'h0000, 1'b0};
        rcp[4] = '{16'h0003, 16'h0003, 16'h0000, 16'h0000, 8'hc8, 16'h0001, 1'b0};
        rcp[5] = '{16'h0001, 16'h0001, 16'h0000, 16'h0000, 8'hc8, 16'h0001, 1'b0};
        cfg = '{3'h4, 2'h2, 1'b1};
        rst_b_i = 1'b0;
        // reset low across two rising edges, released at the second
        repeat (2) @(posedge clk_sys_i);
        rst_b_i <= 1'b1;
        #1;
        check(fmt, {16'h087a, 1'b0, 1'b0, 4'h8});
        check({idle, jet_open}, 2'h2);
        run(1, 3, 5, 1, 13);
        run(1, 3, 3, 1, 11);
        run(2, 2, 3, 3, 8);
        run(3, 0, 0, 0, 0);
        fork
            run(4, 1, 3, 0, 6);
            begin
                repeat (8) @(posedge clk_sys_i);
                i_jrts_robot.pulse(5, 1'b0);
            end
        join
        check(saw_drop, 1'b1);
        run(5, 1, 1, 0, 2);
        run(0, 1, 3, 0, 4);
        repeat (100) @(posedge clk_sys_i);
        run(0, 1, 5, 0, 6);
        for (int i = 0; i < 6; i++) begin
            @(posedge clk_sys_i);
            cfg <= '{i[2:0], i[1:0], i[0]};
            repeat (2) @(posedge clk_sys_i);
            #1;
            check(fmt.bit_div, divs[i]);
            check({fmt.parity_en, fmt.parity_odd}, par[i % 4]);
            check(fmt.data_bits, i[0] ? 4'h7 : 4'h8);
        end
        $display("serial format sweep finished");
        give_verdict();
    end
endmodule

bind jrts_top jrts_top_props #(.TICK_CYCLES(TICK_CYCLES), .TICKS_PER_SEC(TICKS_PER_SEC))
    i_jrts_top_props (.clk_sys_i(clk_sys_i), .rst_b_i(rst_b_i), .trig_i(trig_i),
    .recipe_i(recipe_i), .ser_cfg_i(ser_cfg_i), .ser_fmt_o(ser_fmt_o),
    .jet_open_o(jet_open_o), .jet_idle_flag_o(jet_idle_flag_o),
    .active_recipe_o(active_recipe_o), .trig_dropped_o(trig_dropped_o));
